// ---- shared/bpa_defs.svh ----
// register offsets, field positions and reset values for the address generator
// assumes a 32-bit apb slave with one register per aligned word
`ifndef BPA_DEFS_SVH
`define BPA_DEFS_SVH
`define BPA_OFF_BITREV      12'h000
`define BPA_OFF_MODE        12'h004
`define BPA_OFF_TABLE_PAGE      12'h008
`define BPA_OFF_VISIBILITY_PAGE      12'h00C
`define BPA_OFF_CORE        12'h010
`define BPA_OFF_REQ         12'h014
`define BPA_OFF_DATA_EA     12'h018
`define BPA_OFF_WRITE_EA    12'h01C
`define BPA_OFF_PROG_ADDR   12'h020
`define BPA_OFF_STATUS      12'h024
`define BPA_BITREV_ENABLE_BIT        15
`define BPA_XWM_LSB         0
`define BPA_BWM_LSB         8
`define BPA_X_CIRCULAR_ENABLE_BIT      15
`define BPA_PSV_BIT         2
`define BPA_PTR_NONE        4'hF
`define BPA_RST_BITREV      16'h0000
`define BPA_RST_MODE        16'h0F0F
`define BPA_RST_PAGE        8'h00
`define BPA_RST_CORE 16'h0000
`define BPA_RST_REQ 32'h00000000
`define BPA_RST_EA 16'h0000
`endif

// ---- shared/bpa_pkg.sv ----
// types shared by the address generator
// no assumptions beyond the defs header
package bpa_pkg;
    typedef enum logic [1:0] {
        BPA_MODE_PLAIN = 2'b00,
        BPA_MODE_PREINC = 2'b01,
        BPA_MODE_POSTINC = 2'b10,
        BPA_MODE_OTHER = 2'b11
    } bpa_amode_e;
    typedef enum logic [1:0] {
        BPA_REG_IDLE = 2'b00,
        BPA_REG_ACC = 2'b01
    } bpa_state_e;
endpackage

// ---- rtl/bpa_agu.sv ----
// bit-reversed write addressing and program-space address builder with apb registers
// assumes an apb master on pclk; request registers stand in for the core's execution unit
// outputs are registered and follow the registers and the request one clock later
// Summary of operation
// R1: bit reversal needs pointer select not 15, enable set, pre/post increment mode
// R2: enable is bit 15 of bit-reversal control; pivot modifier in bits 14..0
// R3: software aligns a 2^N byte buffer start so its low N bits are zero
// R4: bit-reversed math is word sized; modifier scaled, address bit 0 forced zero
// R5: bytes, reads and other modes fall back to normal addresses
// R6: modifier added to pointer in reversed bit order, mode offset ignored
// R7: bit reversal wins over circular on write unit; read unit keeps circular
// R8: software avoids pointer read right after rewriting bit-reversal control
// R9: 16-entry buffer yields sequence 0,8,4,12,2,10,6,14,1,9,5,13,3,11,7,15
// R10: 24-bit program words and 16-bit data words keep alignment
// R11: table address is table page above the full 16-bit effective address
// R12: table page bit 7 picks user (0) or configuration (1) memory
// R13: visibility joins page with address bits 14..0 when bit 15 set, user only
// R14: visibility drives bit 23 zero, bit 15 from page bit 0
// R15: visibility is read-only low word; table reaches every byte
// R16: reversed addition carries from msb toward lsb within 15 bits
// R17: x circular only when x pointer select not 15 and x circular enable set
// R18: data-to-program remap only while visibility enable in core control set
`timescale 1ns/1ns
`include "bpa_defs.svh"
module bpa_agu
    import bpa_pkg::*;
#(
    parameter int MOD_W = 15
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // generated addresses
    output logic [15:0] write_ea,
    output logic [23:0] prog_addr,
    output logic prog_valid,
    output logic cfg_space,
    output logic bitrev_active,
    output logic x_write_circular,
    output logic x_read_circular
);
    // register state
    logic [15:0] bit_reversal_control, next_bit_reversal_control;
    logic [15:0] address_mode_control, next_address_mode_control;
    logic [7:0] table_page, next_table_page;
    logic [7:0] visibility_page, next_visibility_page;
    logic [15:0] core_control, next_core_control;
    // request: [15:0] pointer, [19:16] pointer index, [21:20] mode, [22] byte,
    // [23] write, [24] table op, [31:28] signed offset
    logic [31:0] req, next_req;
    logic [15:0] data_ea, next_data_ea;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [15:0] next_write_ea;
    logic [23:0] next_prog_addr;
    logic next_prog_valid, next_cfg_space, next_bitrev_active;
    logic next_x_write_circular, next_x_read_circular;
    logic [1:0] status_err, next_status_err;

    // reversed-order add: the carry runs from msb down to lsb
    function automatic logic [MOD_W-1:0] rev_add(input logic [MOD_W-1:0] a,
                                                  input logic [MOD_W-1:0] b);
        logic [MOD_W-1:0] s;
        logic c;
        s = '0;
        c = 1'b0;
        for (int i = MOD_W - 1; i >= 0; i--) begin
            s[i] = a[i] ^ b[i] ^ c; // R16
            c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
        end
        return s;
    endfunction

    function automatic logic sel_on(input logic [3:0] sel, input logic en);
        return (sel != `BPA_PTR_NONE) && en;
    endfunction

    // whole register map; anything else answers with an error
    function automatic logic reg_mapped(input logic [11:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            `BPA_OFF_BITREV, `BPA_OFF_MODE, `BPA_OFF_TABLE_PAGE, `BPA_OFF_VISIBILITY_PAGE,
            `BPA_OFF_CORE, `BPA_OFF_REQ, `BPA_OFF_DATA_EA, `BPA_OFF_WRITE_EA,
            `BPA_OFF_PROG_ADDR, `BPA_OFF_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // register fields
    logic bitrev_enable;
    logic [14:0] pivot_modifier;
    logic [3:0] bitrev_pointer_select, x_circular_pointer_select;
    logic x_circular_enable, program_visibility_enable;

    // request fields
    logic [15:0] r_ptr;
    logic [3:0] r_idx;
    bpa_amode_e r_mode;
    logic r_byte, r_write, r_table;
    logic [15:0] r_off;

    // address arithmetic
    logic incr_mode, br_hit;
    logic [14:0] word_sum;
    logic [15:0] normal_ea;

    // bus decode and read mux
    logic apb_access, wr_strobe, rd_strobe, mapped;
    logic [31:0] status_word;

    // register fields and request decode
    always_comb begin
        bitrev_enable = bit_reversal_control[`BPA_BITREV_ENABLE_BIT]; // R2
        pivot_modifier = bit_reversal_control[14:0]; // R2
        bitrev_pointer_select = address_mode_control[`BPA_BWM_LSB +: 4];
        x_circular_pointer_select = address_mode_control[`BPA_XWM_LSB +: 4];
        x_circular_enable = address_mode_control[`BPA_X_CIRCULAR_ENABLE_BIT];
        program_visibility_enable = core_control[`BPA_PSV_BIT];
        r_ptr = req[15:0];
        r_idx = req[19:16];
        r_mode = bpa_amode_e'(req[21:20]);
        r_byte = req[22];
        r_write = req[23];
        r_table = req[24];
        r_off = {{12{req[31]}}, req[31:28]};
        incr_mode = (r_mode == BPA_MODE_PREINC) || (r_mode == BPA_MODE_POSTINC);
    end

    // x write path: bit reversal, its fallbacks and the circular override
    // a rewritten modifier reaches write_ea one clock after its write, also for the held request; no bypass
    always_comb begin
        // R1 R5
        br_hit = sel_on(bitrev_pointer_select, bitrev_enable) && incr_mode
                 && r_write && !r_byte && (r_idx == bitrev_pointer_select);
        // word-scaled: bits 15..1 hold the word index, modifier aligned to it
        word_sum = rev_add(r_ptr[15:1], pivot_modifier >> 1); // R4 R6 R9
        // pre-increment uses the offset first; post-increment writes at the pointer
        normal_ea = (r_mode == BPA_MODE_PREINC) ? r_ptr + r_off : r_ptr;
        next_write_ea = br_hit ? {word_sum, 1'b0} : normal_ea; // R4 R5
        next_bitrev_active = br_hit;
        // circular is a per-unit enable; bit reversal overrides only the write unit
        // R7 R17
        next_x_read_circular = sel_on(x_circular_pointer_select, x_circular_enable);
        next_x_write_circular = next_x_read_circular && !br_hit;
    end

    // program path: table ops first, visibility only on data reads
    always_comb begin
        // R11 R12 R13 R14 R15 R18; table ops suspend visibility
        next_prog_addr = 24'h000000;
        next_prog_valid = 1'b0;
        next_cfg_space = 1'b0;
        if (r_table) begin
            next_prog_addr = {table_page, data_ea}; // R11 R10
            next_prog_valid = 1'b1;
            next_cfg_space = table_page[7]; // R12
        end else if (program_visibility_enable && data_ea[15] && !r_write) begin
            // bit 23 stays zero, so visibility never reaches configuration memory
            next_prog_addr = {1'b0, visibility_page, data_ea[14:0]}; // R13 R14
            next_prog_valid = 1'b1; // R15
        end
    end

    // bus decode: writes land at the access edge, reads are taken at setup
    always_comb begin
        apb_access = psel && penable && pready;
        wr_strobe = apb_access && pwrite;
        // read data is captured at setup so it already stands in the access cycle
        rd_strobe = psel && !penable && !pwrite;
        mapped = reg_mapped(paddr);
    end

    // register file
    always_comb begin
        next_bit_reversal_control = bit_reversal_control;
        next_address_mode_control = address_mode_control;
        next_table_page = table_page;
        next_visibility_page = visibility_page;
        next_core_control = core_control;
        next_req = req;
        next_data_ea = data_ea;
        next_status_err = status_err;
        // write_ea and prog_addr are read-only and writes there change nothing; a status write only clears error bits
        if (wr_strobe) begin
            case (paddr)
                `BPA_OFF_BITREV: next_bit_reversal_control = pwdata[15:0];
                `BPA_OFF_MODE: next_address_mode_control = pwdata[15:0];
                `BPA_OFF_TABLE_PAGE: next_table_page = pwdata[7:0];
                `BPA_OFF_VISIBILITY_PAGE: next_visibility_page = pwdata[7:0];
                `BPA_OFF_CORE: next_core_control = pwdata[15:0];
                `BPA_OFF_REQ: next_req = pwdata;
                `BPA_OFF_DATA_EA: next_data_ea = pwdata[15:0];
                default: next_status_err = status_err;
            endcase
        end
        // sticky refused-write flag: ones clear it, a new refused write wins the cycle
        if (wr_strobe && paddr == `BPA_OFF_STATUS)
            next_status_err = status_err & ~pwdata[5:4];
        if (program_visibility_enable && data_ea[15] && r_write && !r_table)
            next_status_err[0] = 1'b1; // R15
    end

    // slave response: exactly one access cycle after every setup
    always_comb begin
        next_pready = psel && !penable;
        next_pslverr = psel && !penable && !mapped;
        // status bits 3..0 mirror the registered outputs, bits 5..4 hold the error flags
        status_word = 32'h00000000;
        status_word[0] = bitrev_active;
        status_word[1] = x_write_circular;
        status_word[2] = prog_valid;
        status_word[3] = cfg_space;
        status_word[5:4] = status_err;
        next_prdata = prdata;
        if (rd_strobe) begin
            case (paddr)
                `BPA_OFF_BITREV: next_prdata = {16'h0000, bit_reversal_control};
                `BPA_OFF_MODE: next_prdata = {16'h0000, address_mode_control};
                `BPA_OFF_TABLE_PAGE: next_prdata = {24'h000000, table_page};
                `BPA_OFF_VISIBILITY_PAGE: next_prdata = {24'h000000, visibility_page};
                `BPA_OFF_CORE: next_prdata = {16'h0000, core_control};
                `BPA_OFF_REQ: next_prdata = req;
                `BPA_OFF_DATA_EA: next_prdata = {16'h0000, data_ea};
                `BPA_OFF_WRITE_EA: next_prdata = {16'h0000, write_ea};
                `BPA_OFF_PROG_ADDR: next_prdata = {8'h00, prog_addr};
                `BPA_OFF_STATUS: next_prdata = status_word;
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    // register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_reversal_control <= `BPA_RST_BITREV;
            address_mode_control <= `BPA_RST_MODE;
            table_page <= `BPA_RST_PAGE;
            visibility_page <= `BPA_RST_PAGE;
            core_control <= `BPA_RST_CORE;
            req <= `BPA_RST_REQ;
            data_ea <= `BPA_RST_EA;
            status_err <= 2'b00;
        end else begin
            bit_reversal_control <= next_bit_reversal_control;
            address_mode_control <= next_address_mode_control;
            table_page <= next_table_page;
            visibility_page <= next_visibility_page;
            core_control <= next_core_control;
            req <= next_req;
            data_ea <= next_data_ea;
            status_err <= next_status_err;
        end
    end

    // slave response
    // pready and pslverr stand for the one access cycle only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // x write path outputs; flag and address come from the same request and settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_ea <= 16'h0000;
            bitrev_active <= 1'b0;
            x_write_circular <= 1'b0;
            x_read_circular <= 1'b0;
        end else begin
            write_ea <= next_write_ea;
            bitrev_active <= next_bitrev_active;
            x_write_circular <= next_x_write_circular;
            x_read_circular <= next_x_read_circular;
        end
    end

    // program path outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_addr <= 24'h000000;
            prog_valid <= 1'b0;
            cfg_space <= 1'b0;
        end else begin
            prog_addr <= next_prog_addr;
            prog_valid <= next_prog_valid;
            cfg_space <= next_cfg_space;
        end
    end
endmodule // bpa_agu

// ---- sim/bpa_mem_model.sv ----
// program memory stand-in: records which space each fetch lands in
// assumes prog_addr and cfg_space are qualified by prog_valid
`timescale 1ns/1ns
module bpa_mem_model (
    // address side
    input wire logic pclk,
    input wire logic [23:0] prog_addr,
    input wire logic prog_valid,
    input wire logic cfg_space,
    // observation
    output logic space_cfg
);
    initial space_cfg = 1'b0;
    // the array decodes its space from bit 23 alone, not from cfg_space
    always @(posedge pclk) begin
        if (prog_valid === 1'b1) space_cfg <= prog_addr[23];
    end
endmodule // bpa_mem_model

// ---- sim/bpa_agu_properties.sv ----
// port assertions for the address generator
// assumes one pclk domain with presetn as its reset
`timescale 1ns/1ns
module bpa_agu_properties (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // generated
    input wire logic [15:0] write_ea,
    input wire logic [23:0] prog_addr,
    input wire logic prog_valid,
    input wire logic cfg_space,
    input wire logic bitrev_active,
    input wire logic x_write_circular,
    input wire logic x_read_circular
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    assign wr = psel && penable && pready && pwrite;
    a_setup_gets_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_bitrev_even_ea: assert property (bitrev_active |-> !write_ea[0])
        else $error("odd bit-reversed address");
    a_bitrev_beats_circ: assert property (bitrev_active |-> !x_write_circular)
        else $error("write circular beside bit reversal");
    a_read_circ_kept: assert property (x_write_circular |-> x_read_circular)
        else $error("read circular lost");
    a_cfg_space_bit: assert property (cfg_space |-> prog_valid && prog_addr[23])
        else $error("config space without bit 23");
    a_user_space_bit: assert property (prog_valid && !cfg_space |-> !prog_addr[23])
        else $error("user space with bit 23");
    a_enable_off: assert property (wr && paddr == 12'h000 && !pwdata[15] |-> ##2 !bitrev_active)
        else $error("bit reversal without enable");
    a_select_none: assert property (wr && paddr == 12'h004 && pwdata[11:8] == 4'hF
        |-> ##2 !bitrev_active)
        else $error("bit reversal with select 15");
    a_circ_off: assert property (wr && paddr == 12'h004 && !pwdata[15] |-> ##2 !x_read_circular)
        else $error("circular without enable");
    c_bitrev: cover property (bitrev_active);
    c_cfg: cover property (cfg_space);
    c_user: cover property (prog_valid && !cfg_space);
endmodule // bpa_agu_properties
bind bpa_agu bpa_agu_properties bpa_agu_properties_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .write_ea, .prog_addr, .prog_valid,
    .cfg_space, .bitrev_active, .x_write_circular, .x_read_circular);

// ---- sim/tb_top.sv ----
// self-checking bench for the address generator
// assumes design, checker bind and memory model are compiled first
`timescale 1ns/1ns
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, se, pv, cfg, br, xwc, xrc, mcfg;
    logic [15:0] ea;
    logic [23:0] pa;
    int errors = 0, tests_run = 0;
    int sq [16] = '{0, 8, 4, 12, 2, 10, 6, 14, 1, 9, 5, 13, 3, 11, 7, 15};
    always #50 pclk = ~pclk;
    bpa_agu bpa_agu_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .write_ea(ea), .prog_addr(pa), .prog_valid(pv),
        .cfg_space(cfg), .bitrev_active(br), .x_write_circular(xwc), .x_read_circular(xrc));
    bpa_mem_model bpa_mem_model_inst (.pclk, .prog_addr(pa), .prog_valid(pv),
        .cfg_space(cfg), .space_cfg(mcfg));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string s);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) cmp(0, 1, "apb hang");
        rd = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // generated outputs follow one edge after the write edge
    task automatic settle;
        @(posedge pclk);
        #1;
    endtask
    function automatic logic [31:0] rq(input int p, input logic [1:0] m, input logic by,
        input logic w, input logic t);
        return {4'h2, 3'b0, t, w, by, m, 4'h4, 16'(p)};
    endfunction
    task automatic t_reset;
        apb(0, 12'h000, 0);
        cmp(rd, 32'h0, "bitrev ctrl reset");
        apb(0, 12'h004, 0);
        cmp(rd, 32'h0F0F, "mode ctrl reset");
        apb(0, 12'h028, 0);
        cmp({rd[30:0], se}, 32'h1, "unmapped");
        $display("reset test done");
    endtask
    task automatic t_bitrev;
        apb(1, 12'h004, 32'h8404);
        apb(1, 12'h000, 32'h8010);
        for (int i = 0; i < 16; i++) begin
            apb(1, 12'h014, rq(sq[i] * 2, 2'(1 + i % 2), 0, 1, 0));
            settle;
            cmp(ea, sq[(i + 1) % 16] * 2, "bitrev ea");
            cmp({xrc, xwc, br}, 3'b101, "bitrev flags");
        end
        apb(1, 12'h014, rq(16, 2, 1, 1, 0));
        settle;
        cmp({ea, br}, {16'h0010, 1'b0}, "byte fallback");
        foreach (sq[k]) if (k < 3) begin
            apb(1, 12'h014, rq(16, 2'(k * 3 / 2), 0, k != 1, 0));
            settle;
            cmp(br, 0, "mode or read fallback");
            cmp(ea, k == 1 ? 18 : 16, "fallback ea");
        end
        apb(1, 12'h004, 32'h8F04);
        apb(1, 12'h014, 32'h20AF0010);
        settle;
        cmp({xrc, xwc, br}, 3'b110, "select none");
        apb(1, 12'h004, 32'h0404);
        apb(1, 12'h014, rq(16, 2, 0, 1, 0));
        settle;
        cmp({xrc, xwc, br, ea}, {3'b001, 16'h0008}, "circular off");
        apb(1, 12'h000, 32'h0010);
        apb(1, 12'h014, rq(16, 2, 0, 1, 0));
        settle;
        cmp({br, ea}, {1'b0, 16'h0010}, "enable off");
        $display("bitrev test done");
    endtask
    task automatic t_prog;
        foreach (sq[k]) if (k < 2) begin
            apb(1, 12'h008, k ? 32'h85 : 32'h05);
            apb(1, 12'h018, 32'h1234);
            apb(1, 12'h014, rq(0, 0, 0, 0, 1));
            settle;
            cmp({cfg, pa}, {k[0], k ? 24'h851234 : 24'h051234}, "table");
            settle;
            cmp(mcfg, k[0], "memory space");
        end
        apb(1, 12'h010, 4);
        apb(1, 12'h00C, 32'hA5);
        apb(1, 12'h018, 32'h8ABC);
        apb(1, 12'h014, rq(0, 0, 0, 0, 0));
        settle;
        cmp({cfg, pv, pa}, {2'b01, 24'h528ABC}, "visibility");
        apb(1, 12'h010, 0);
        settle;
        cmp(pv, 0, "visibility off");
        apb(1, 12'h010, 4);
        apb(1, 12'h018, 32'h0ABC);
        settle;
        cmp(pv, 0, "low data half");
        apb(1, 12'h018, 32'h8ABC);
        apb(1, 12'h014, rq(0, 0, 0, 1, 0));
        settle;
        apb(0, 12'h024, 0);
        cmp({pv, rd[4]}, 2'b01, "visibility write");
        $display("program space test done");
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_bitrev;
        t_prog;
        end_sim;
    end
    // run needs well under 1000 cycles
    initial begin
        #300000;
        errors++;
        end_sim;
    end
endmodule // tb_top
